// ==== sspt_pkg.sv ====
package sspt_pkg;
   localparam int WORD_W = 16;
   localparam int DEPTH = 8;
   localparam int PTR_W = 3;
   localparam int CNT_W = 4;
   localparam int LEN_W = 4;
   localparam logic [CNT_W-1:0] DEPTH_CNT = 4'h8;
   localparam logic [CNT_W-1:0] HALF_MARK = 4'h4;
   localparam logic [LEN_W-1:0] MIN_LEN_M1 = 4'h3;
   localparam logic [LEN_W-1:0] MAX_LEN_M1 = 4'hf;
   localparam logic [WORD_W-1:0] ALL_ONES = 16'hffff;
   localparam logic [1:0] FMT_SPI = 2'h0;
   localparam logic [1:0] FMT_SSI = 2'h1;
   localparam logic [1:0] FMT_MW = 2'h2;
   // link clock cycles per serial clock half period, minus one
   localparam int HC_W = 3;
   localparam logic [HC_W-1:0] HALF_LAST = 3'h3;
   localparam int CLK_PERIOD_NS = 4;
   localparam int RX_TIMEOUT_NS = 4000;
   localparam int RX_TIMEOUT_CYC = RX_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int TO_W = 10;
   localparam logic [TO_W-1:0] TO_LAST = TO_W'(RX_TIMEOUT_CYC - 1);

   typedef struct packed {
      logic enable;
      logic slave;
      logic [1:0] fmt;
      logic cpol;
      logic [LEN_W-1:0] len_m1;
   } sspt_cfg_type;

   typedef struct packed {
      logic sck;
      logic ssel;
      logic miso;
      logic mosi;
   } sspt_pin_in_type;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic ssel_o;
      logic ssel_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
   } sspt_pin_out_type;

   typedef struct packed {
      logic tx_half;
      logic rx_half;
      logic rx_timeout;
      logic rx_overrun;
   } sspt_irq_type;

   typedef enum logic [3:0] {
      LK_IDLE = 4'h1,
      LK_SYNC = 4'h2,
      LK_BITS = 4'h4,
      LK_END = 4'h8
   } sspt_link_state_type;
endpackage

// ==== sspt_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspt_sync
   #(parameter int W = 1)
   (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
   );
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      meta_q <= d;
      q <= meta_q;
   end
endmodule
`default_nettype wire

// ==== sspt_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspt_fifo
   import sspt_pkg::*;
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [WORD_W-1:0] wdata,
   input wire logic pop,
   output logic [WORD_W-1:0] rdata_q,
   output logic [CNT_W-1:0] count_q,
   output logic not_full_q,
   output logic not_empty_q
   );
   logic [WORD_W-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_q;
   logic [PTR_W-1:0] rd_q;
   logic [PTR_W-1:0] rd_next;
   logic [CNT_W-1:0] cnt_d;
   logic do_push;
   logic do_pop;

   always_comb begin
      do_pop = pop && not_empty_q;
      do_push = push && (not_full_q || do_pop);
      rd_next = do_pop ? PTR_W'(rd_q + PTR_W'(1)) : rd_q;
      cnt_d = CNT_W'(count_q + CNT_W'(do_push) - CNT_W'(do_pop));
   end

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wr_q] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
         not_full_q <= 1'b1;
         not_empty_q <= 1'b0;
      end else begin
         if (do_push) begin
            wr_q <= PTR_W'(wr_q + PTR_W'(1));
         end
         rd_q <= rd_next;
         count_q <= cnt_d;
         not_full_q <= cnt_d != DEPTH_CNT;
         not_empty_q <= cnt_d != '0;
      end
   end

   // head word is registered; bypass covers a write into the empty slot
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (do_push && wr_q == rd_next) begin
         rdata_q <= wdata;
      end else begin
         rdata_q <= mem_q[rd_next];
      end
   end
endmodule
`default_nettype wire

// ==== sspt_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspt_top
   import sspt_pkg::*;
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire sspt_cfg_type cfg,
   input wire logic tx_valid,
   input wire logic [WORD_W-1:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [WORD_W-1:0] rx_data,
   input wire logic rx_ready,
   input wire logic ovr_clr,
   output sspt_irq_type irq,
   input wire sspt_pin_in_type pin_in,
   output sspt_pin_out_type pin_out
   );
   ////////////////////////////////////////////////////////////////////////
   logic [WORD_W-1:0] tx_head;
   logic [CNT_W-1:0] tx_count;
   logic tx_not_empty;
   logic tx_pop;
   logic [CNT_W-1:0] rx_count;
   logic rx_not_full;
   logic rx_pop;
   logic [WORD_W-1:0] xfer_q;
   logic req_q;
   logic ack_s;
   logic rx_tgl_s;
   logic rx_seen_q;
   logic rx_arrive;
   logic [TO_W-1:0] to_cnt_q;
   sspt_irq_type irq_q;
   // link domain
   logic lrst_n;
   sspt_cfg_type cfg_l;
   sspt_pin_in_type pin_s;
   logic req_s;
   sspt_link_state_type st_q;
   sspt_link_state_type st_d;
   logic [HC_W-1:0] hc_q;
   logic [HC_W-1:0] hc_d;
   logic ph_q;
   logic ph_d;
   logic [LEN_W-1:0] cnt_q;
   logic [WORD_W-1:0] tx_sh_q;
   logic [WORD_W-1:0] rx_sh_q;
   logic [WORD_W-1:0] rx_word_q;
   logic rx_tgl_q;
   logic ack_q;
   logic sck_prev_q;
   sspt_pin_out_type pin_q;
   logic [LEN_W-1:0] len_l;
   logic idle_lvl;
   logic is_ssi;
   logic master;
   logic slave_on;
   logic lead;
   logic trail;
   logic sel_in;
   logic pending;
   logic m_tick;
   logic din;
   logic last_bit;
   logic load;
   logic sample;
   logic shift;
   logic done;
   logic [WORD_W-1:0] ldw;
   logic [WORD_W-1:0] rx_full_word;

   function automatic logic [WORD_W-1:0] shift_in(
      input logic [WORD_W-1:0] sh,
      input logic b);
      return {sh[WORD_W-2:0], b};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // queues on the system clock

   sspt_fifo u_tx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .push(tx_valid && tx_ready),
      .wdata(tx_data),
      .pop(tx_pop),
      .rdata_q(tx_head),
      .count_q(tx_count),
      .not_full_q(tx_ready),
      .not_empty_q(tx_not_empty)
   );

   assign rx_pop = rx_ready && rx_valid;

   sspt_fifo u_rx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .push(rx_arrive),
      .wdata(rx_word_q),
      .pop(rx_pop),
      .rdata_q(rx_data),
      .count_q(rx_count),
      .not_full_q(rx_not_full),
      .not_empty_q(rx_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // word handshakes between the domains

   sspt_sync #(.W(1)) u_ack_sync (.clk(clk), .d(ack_q), .q(ack_s));
   sspt_sync #(.W(1)) u_rxt_sync (.clk(clk), .d(rx_tgl_q), .q(rx_tgl_s));

   // xfer_q is held until the link acknowledges it
   assign tx_pop = tx_not_empty && (req_q == ack_s);
   assign rx_arrive = rx_tgl_s ^ rx_seen_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xfer_q <= '0;
         req_q <= 1'b0;
      end else if (tx_pop) begin
         xfer_q <= tx_head;
         req_q <= ~req_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_seen_q <= 1'b0;
      end else begin
         rx_seen_q <= rx_tgl_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request lines

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         to_cnt_q <= '0;
      end else if (rx_arrive || rx_pop || !rx_valid) begin
         to_cnt_q <= '0;
      end else if (to_cnt_q != TO_LAST) begin
         to_cnt_q <= TO_W'(to_cnt_q + TO_W'(1));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_q <= '0;
      end else begin
         irq_q.tx_half <= tx_count <= HALF_MARK;
         irq_q.rx_half <= rx_count >= HALF_MARK;
         irq_q.rx_timeout <= rx_valid && !rx_arrive && !rx_pop &&
                             to_cnt_q == TO_LAST;
         // a new overrun wins over a clear in the same cycle
         irq_q.rx_overrun <= (irq_q.rx_overrun && !ovr_clr) ||
                             (rx_arrive && !rx_not_full && !rx_pop);
      end
   end

   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // link clock domain

   sspt_sync #(.W(1)) u_rst_sync (.clk(link_clk), .d(rst_n), .q(lrst_n));
   sspt_sync #(.W($bits(sspt_cfg_type))) u_cfg_sync (
      .clk(link_clk),
      .d(cfg),
      .q(cfg_l)
   );
   sspt_sync #(.W($bits(sspt_pin_in_type))) u_pin_sync (
      .clk(link_clk),
      .d(pin_in),
      .q(pin_s)
   );
   sspt_sync #(.W(1)) u_req_sync (.clk(link_clk), .d(req_q), .q(req_s));

   always_comb begin
      len_l = (cfg_l.len_m1 < MIN_LEN_M1) ? MIN_LEN_M1 : cfg_l.len_m1;
      idle_lvl = (cfg_l.fmt == FMT_SPI) ? cfg_l.cpol : 1'b0;
      is_ssi = cfg_l.fmt == FMT_SSI;
      master = cfg_l.enable && !cfg_l.slave;
      slave_on = cfg_l.enable && cfg_l.slave;
      lead = (pin_s.sck ^ idle_lvl) && !(sck_prev_q ^ idle_lvl);
      trail = !(pin_s.sck ^ idle_lvl) && (sck_prev_q ^ idle_lvl);
      sel_in = is_ssi ? pin_s.ssel : !pin_s.ssel;
      pending = req_s ^ ack_q;
      m_tick = hc_q == HALF_LAST;
      din = cfg_l.slave ? pin_s.mosi : pin_s.miso;
      last_bit = cnt_q == len_l;
      ldw = pending ? xfer_q : '0;
      rx_full_word = shift_in(rx_sh_q, din) &
                     (ALL_ONES >> (MAX_LEN_M1 - len_l));
   end

   // sequencing: master times its own clock, slave follows edges
   always_comb begin
      st_d = st_q;
      hc_d = '0;
      ph_d = 1'b0;
      load = 1'b0;
      sample = 1'b0;
      shift = 1'b0;
      done = 1'b0;
      if (master) begin
         if (st_q != LK_IDLE) begin
            hc_d = m_tick ? '0 : HC_W'(hc_q + HC_W'(1));
            ph_d = m_tick ? ~ph_q : ph_q;
         end
         unique case (st_q)
            LK_IDLE: begin
               if (pending) begin
                  load = 1'b1;
                  st_d = LK_SYNC;
               end
            end
            LK_SYNC: begin
               if (m_tick && ph_q) begin
                  st_d = LK_BITS;
               end
            end
            LK_BITS: begin
               if (m_tick && ph_q) begin
                  sample = 1'b1;
                  if (last_bit) begin
                     done = 1'b1;
                     st_d = LK_END;
                  end else begin
                     shift = 1'b1;
                  end
               end
            end
            LK_END: begin
               if (m_tick) begin
                  st_d = LK_IDLE;
               end
            end
         endcase
      end else if (slave_on) begin
         unique case (st_q)
            LK_IDLE: begin
               if (sel_in && (!is_ssi || lead)) begin
                  load = 1'b1;
                  st_d = LK_BITS;
               end
            end
            LK_BITS: begin
               if (!is_ssi && !sel_in) begin
                  st_d = LK_IDLE;
               end else begin
                  if (lead) begin
                     sample = 1'b1;
                     if (last_bit) begin
                        done = 1'b1;
                        st_d = is_ssi ? LK_IDLE : LK_END;
                     end
                  end
                  shift = trail && cnt_q != '0;
               end
            end
            LK_SYNC, LK_END: begin
               if (!sel_in || is_ssi) begin
                  st_d = LK_IDLE;
               end
            end
         endcase
      end else begin
         st_d = LK_IDLE;
      end
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         st_q <= LK_IDLE;
         hc_q <= '0;
         ph_q <= 1'b0;
         cnt_q <= '0;
         sck_prev_q <= 1'b0;
      end else begin
         st_q <= st_d;
         hc_q <= hc_d;
         ph_q <= ph_d;
         sck_prev_q <= pin_s.sck;
         if (load) begin
            cnt_q <= '0;
         end else if (sample && !last_bit) begin
            cnt_q <= LEN_W'(cnt_q + LEN_W'(1));
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         tx_sh_q <= '0;
         rx_sh_q <= '0;
         rx_word_q <= '0;
         rx_tgl_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         if (load) begin
            tx_sh_q <= ldw;
            rx_sh_q <= '0;
            ack_q <= ack_q ^ pending;
         end else begin
            if (shift) begin
               tx_sh_q <= tx_sh_q << 1;
            end
            if (sample) begin
               rx_sh_q <= shift_in(rx_sh_q, din);
            end
         end
         if (done) begin
            rx_word_q <= rx_full_word;
            rx_tgl_q <= ~rx_tgl_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers, all from flops

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         pin_q <= '0;
      end else begin
         pin_q.sck_oe <= master;
         pin_q.sck_o <= idle_lvl ^ (master && ph_d &&
            (st_d == LK_BITS || (st_d == LK_SYNC && is_ssi)));
         pin_q.ssel_oe <= master;
         pin_q.ssel_o <= is_ssi ? (st_d == LK_SYNC) :
            !(st_d == LK_SYNC || st_d == LK_BITS);
         pin_q.mosi_oe <= master;
         pin_q.miso_oe <= slave_on && (sel_in || is_ssi) &&
            (st_d == LK_BITS || st_d == LK_END);
         if (load) begin
            pin_q.mosi_o <= ldw[len_l];
            pin_q.miso_o <= ldw[len_l];
         end else if (shift) begin
            pin_q.mosi_o <= tx_sh_q[LEN_W'(len_l - LEN_W'(1))];
            pin_q.miso_o <= tx_sh_q[LEN_W'(len_l - LEN_W'(1))];
         end
      end
   end

   assign pin_out = pin_q;
endmodule
`default_nettype wire

// ==== sspt_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspt_chk
   import sspt_pkg::*;
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire sspt_cfg_type cfg,
   input wire logic rx_valid,
   input wire logic [WORD_W-1:0] rx_data,
   input wire logic rx_ready,
   input wire logic ovr_clr,
   input wire sspt_irq_type irq,
   input wire sspt_pin_in_type pin_in,
   input wire sspt_pin_out_type pin_out
   );
   logic mst;
   logic slv;
   assign mst = cfg.enable && !cfg.slave;
   assign slv = cfg.enable && cfg.slave;
   ////////////////////////////////////////////////////////////////////////////
   a_slave_sck_free: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      slv [*4] |-> !pin_out.sck_oe) else $error("slave drives sck");
   a_master_pins_on: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      mst [*4] |-> pin_out.sck_oe && pin_out.mosi_oe && !pin_out.miso_oe)
      else $error("master pin drive wrong");
   a_sck_idle_level: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      (mst && cfg.fmt != FMT_SSI && pin_out.ssel_o) [*4]
      |-> pin_out.sck_o == (cfg.fmt == FMT_SPI && cfg.cpol))
      else $error("sck not idle");
   a_clk_in_frame: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      mst && !cfg.cpol && cfg.fmt != FMT_SSI && $rose(pin_out.sck_o)
      |-> !pin_out.ssel_o) else $error("sck outside frame");
   a_slave_miso_off: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      (slv && cfg.fmt != FMT_SSI && pin_in.ssel) [*6] |-> !pin_out.miso_oe)
      else $error("miso driven unselected");
   a_rx_head_holds: assert property (
      @(posedge clk) disable iff (!rst_n)
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("rx head lost");
   a_rx_empty_quiet: assert property (
      @(posedge clk) disable iff (!rst_n)
      !rx_valid [*2] |-> !irq.rx_half && !irq.rx_timeout)
      else $error("rx request while empty");
   a_ovr_sticky: assert property (
      @(posedge clk) disable iff (!rst_n)
      irq.rx_overrun && !ovr_clr |=> irq.rx_overrun)
      else $error("overrun flag dropped");
   c_overrun: cover property (@(posedge clk) $rose(irq.rx_overrun));
   c_timeout: cover property (@(posedge clk) $rose(irq.rx_timeout));
   c_slave_out: cover property (@(posedge link_clk) $rose(pin_out.miso_oe));
endmodule
bind sspt_top sspt_chk u_sspt_chk (.clk(clk), .rst_n(rst_n),
   .link_clk(link_clk), .cfg(cfg), .rx_valid(rx_valid), .rx_data(rx_data),
   .rx_ready(rx_ready), .ovr_clr(ovr_clr), .irq(irq), .pin_in(pin_in),
   .pin_out(pin_out));
`default_nettype wire

// ==== sspt_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side slave; replies base plus its frame count
module sspt_peer
   import sspt_pkg::*;
   (
   input wire logic arm,
   input wire sspt_cfg_type cfg,
   input wire logic [WORD_W-1:0] base,
   input wire logic sck,
   input wire logic ssel,
   input wire logic mosi,
   output logic miso,
   output logic [7:0] nfr,
   output logic [WORD_W-1:0] got
   );
   logic [WORD_W-1:0] sr = '0;
   logic [WORD_W-1:0] rx = '0;
   logic [4:0] left = '0;
   logic live = 1'b0;
   logic skip = 1'b0;
   logic last = 1'b0;
   logic lead;
   logic ssi;
   logic [LEN_W-1:0] ln;
   assign ssi = cfg.fmt == FMT_SSI;
   assign ln = (cfg.len_m1 < MIN_LEN_M1) ? MIN_LEN_M1 : cfg.len_m1;
   assign lead = sck ^ (cfg.fmt == FMT_SPI && cfg.cpol);
   // shifts its reply out only while a frame is live, drives the inverted last bit otherwise; never drives the clock
   assign miso = live ? sr[ln] : ~last;
   initial nfr = '0;
   initial got = '0;
   task automatic start;
      sr = base + 16'(nfr);
      rx = '0;
      left = 5'(ln) + 5'h1;
      live = 1'b1;
   endtask
   always @(negedge ssel) begin
      if (arm && !ssi) begin
         start;
      end
   end
   always @(posedge lead) begin
      if (arm && ssi && ssel && !live) begin
         start;
         skip = 1'b1;
      end else if (live && !skip) begin
         rx = {rx[WORD_W-2:0], mosi};
         left = left - 5'h1;
      end
   end
   always @(negedge lead) begin
      if (skip) begin
         skip = 1'b0;
      end else if (live && left == 5'h0) begin
         live = 1'b0;
         last = sr[ln];
         got = rx;
         nfr = nfr + 8'h1;
      end else if (live) begin
         sr = sr << 1;
      end
   end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sspt_pkg::*;
   logic clk, link_clk, rst_n, tx_valid, tx_ready, rx_valid, rx_ready;
   logic ovr_clr, arm, m_sck, m_ssel, m_mosi, p_miso;
   logic [WORD_W-1:0] tx_data, rx_data, base, got;
   logic [7:0] nfr;
   sspt_cfg_type cfg;
   sspt_irq_type irq;
   sspt_pin_in_type pin_in;
   sspt_pin_out_type pin_out;
   int n_fail, n_tests;
   assign pin_in.sck = pin_out.sck_oe ? pin_out.sck_o : m_sck;
   assign pin_in.ssel = pin_out.ssel_oe ? pin_out.ssel_o : m_ssel;
   assign pin_in.mosi = pin_out.mosi_oe ? pin_out.mosi_o : m_mosi;
   assign pin_in.miso = pin_out.miso_oe ? pin_out.miso_o : p_miso;
   sspt_top u_sspt_top (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
      .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .ovr_clr(ovr_clr), .irq(irq), .pin_in(pin_in), .pin_out(pin_out));
   sspt_peer u_sspt_peer (.arm(arm), .cfg(cfg), .base(base),
      .sck(pin_in.sck), .ssel(pin_in.ssel), .mosi(pin_in.mosi),
      .miso(p_miso), .nfr(nfr), .got(got));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #37;
      forever #62.5 link_clk = ~link_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e, string s);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s %h not %h", $time, s, g, e);
      end
   endtask
   task automatic push(input logic [WORD_W-1:0] w);
      tx_data <= w;
      tx_valid <= 1'b1;
      @(posedge clk);
      while (!tx_ready) @(posedge clk);
      tx_valid <= 1'b0;
      wt(1);
   endtask
   task automatic pop;
      rx_ready <= 1'b1;
      wt(1);
      rx_ready <= 1'b0;
      wt(2);
   endtask
   task automatic wait_nfr(input logic [7:0] t);
      for (int i = 0; i < 30000 && nfr != t; i++) wt(1);
      wt(20);
   endtask
   task automatic setup(logic s, logic [1:0] f, logic c, logic [3:0] l);
      cfg.enable <= 1'b0;
      arm <= 1'b0;
      wt(100);
      cfg <= '{enable: 1'b0, slave: s, fmt: f, cpol: c, len_m1: l};
      wt(100);
      cfg.enable <= 1'b1;
      arm <= !s;
      wt(100);
   endtask
   task automatic mframe(input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] msk;
      logic [WORD_W-1:0] e;
      msk = ALL_ONES >> (MAX_LEN_M1 - ((cfg.len_m1 < MIN_LEN_M1) ?
         MIN_LEN_M1 : cfg.len_m1));
      e = (base + 16'(nfr)) & msk;
      push(w);
      wait_nfr(nfr + 8'h1);
      chk(rx_data, e, "rx word");
      chk(got, w & msk, "peer word");
      pop;
   endtask
   task automatic t_formats;
      logic [6:0] tb [5];
      tb = '{7'h07, 7'h1f, 7'h23, 7'h4b, 7'h01};
      for (int i = 0; i < 5; i++) begin
         setup(1'b0, tb[i][6:5], tb[i][4], tb[i][3:0]);
         mframe(16'h9c35 ^ 16'(i * 4369));
      end
   endtask
   task automatic t_overrun;
      logic [7:0] n0;
      setup(1'b0, FMT_SPI, 1'b0, 4'h7);
      cfg.enable <= 1'b0;
      wt(100);
      // the first word waits in the hand-over register, eight fill the queue
      for (int i = 0; i < 9; i++) push(16'h0f00 + 16'(i));
      wt(2);
      chk(16'({tx_ready, irq.tx_half}), 16'h0, "tx full");
      tx_valid <= 1'b1;
      wt(3);
      tx_valid <= 1'b0;
      n0 = nfr;
      cfg.enable <= 1'b1;
      wait_nfr(n0 + 8'h8);
      chk(16'(irq), 16'hc, "rx full");
      push(16'h00aa);
      // frames nine and ten both land on a full receive queue
      wait_nfr(n0 + 8'ha);
      chk(got, 16'h00aa, "refused word");
      chk(16'(irq.rx_overrun), 16'h1, "overrun");
      wt(1100);
      chk(16'(irq.rx_timeout), 16'h1, "timeout");
      for (int k = 0; k < 8; k++) begin
         chk(rx_data, (base + 16'(n0) + 16'(k)) & 16'hff, "kept");
         pop;
      end
      chk(16'({rx_valid, irq}), 16'h09, "drained");
      ovr_clr <= 1'b1;
      wt(1);
      ovr_clr <= 1'b0;
      wt(2);
      chk(16'(irq.rx_overrun), 16'h0, "overrun clear");
   endtask
   task automatic sframe(input logic ssi, input logic [7:0] w, r);
      logic [7:0] cap;
      setup(1'b1, ssi ? FMT_SSI : FMT_SPI, 1'b0, 4'h7);
      push(16'(r));
      wt(100);
      chk(16'(pin_out.miso_oe), 16'h0, "miso idle");
      m_ssel <= ssi;
      if (ssi) begin
         wt(250);
         m_sck <= 1'b1;
         wt(250);
         m_sck <= 1'b0;
         m_ssel <= 1'b0;
      end
      wt(250);
      for (int i = 7; i >= 0; i--) begin
         m_mosi <= w[i];
         wt(250);
         cap[i] = pin_in.miso;
         m_sck <= 1'b1;
         wt(250);
         m_sck <= 1'b0;
      end
      wt(250);
      m_ssel <= !ssi;
      m_mosi <= ~m_mosi;
      wait_nfr(nfr);
      for (int i = 0; i < 2000 && !rx_valid; i++) wt(1);
      chk(rx_data, 16'(w), "slave rx");
      chk(16'(cap), 16'(r), "slave tx");
      pop;
   endtask
   task automatic test_done;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      wt(90000);
      n_fail++;
      test_done;
   end
   initial begin
      rst_n = 1'b0;
      cfg = '0;
      {tx_valid, rx_ready, ovr_clr, arm, m_sck, m_mosi} = '0;
      m_ssel = 1'b1;
      tx_data = '0;
      base = 16'h3c61;
      n_fail = 0;
      n_tests = 0;
      repeat (5) @(posedge link_clk);
      @(posedge clk);
      chk(16'({tx_ready, rx_valid, irq, pin_out}), 16'h2000, "reset");
      rst_n <= 1'b1;
      wt(2);
      t_formats;
      t_overrun;
      sframe(1'b0, 8'hc6, 8'h3b);
      m_ssel <= 1'b0;
      sframe(1'b1, 8'h2d, 8'hd4);
      test_done;
   end
endmodule
`default_nettype wire
